//--- adcc_ctrl.v
// converter control: register file on an axi4-lite slave, start logic and sequencer hookup
//
// Overview of operation
// - result kept as high byte bits 9..2 and low byte bits 7..6 for bits 1..0.
// - result registers readable any time; content during conversion is not meaningful.
// - finished result stays unchanged until the next conversion begins.
// - reset does not touch the result registers.
// - mode register resets to 30 hex; bits 5 and 4 fixed at one.
// - speed bit 0 gives a 62-cycle conversion, 1 gives 31 cycles.
// - trigger enable 0 ignores the trigger pin; 1 lets an edge start conversion.
// - edge select bit picks rising or falling trigger edge.
// - eight analog inputs, one converted per conversion.
// - write 1 starts, flag reads 1 while busy, clears on load, write 0 stops.
// - channel 00xx none, 01xx inputs 0-3, 10xx inputs 4-7, 11xx prohibited.
// - enabled trigger edge sets the start flag and begins a conversion.
// - flag falling at end sets request flag; interrupt only when enabled.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.vh"

module adcc_ctrl #(
	parameter ADDR_W = 18,
	parameter RES_W  = 10,
	parameter NCH    = 8
) (
	// clock and reset
	input  wire              aclk,
	input  wire              aresetn,
	// axi4-lite write address
	input  wire [ADDR_W-1:0] awaddr,
	input  wire [2:0]        awprot,
	input  wire              awvalid,
	output wire              awready,
	// axi4-lite write data
	input  wire [31:0]       wdata,
	input  wire [3:0]        wstrb,
	input  wire              wvalid,
	output wire              wready,
	// axi4-lite write response
	output reg  [1:0]        bresp,
	output reg               bvalid,
	input  wire              bready,
	// axi4-lite read address
	input  wire [ADDR_W-1:0] araddr,
	input  wire [2:0]        arprot,
	input  wire              arvalid,
	output wire              arready,
	// axi4-lite read data
	output reg  [31:0]       rdata,
	output reg  [1:0]        rresp,
	output reg               rvalid,
	input  wire              rready,
	// analog side
	input  wire              external_trigger_pin,
	input  wire              comparator_high,
	output reg  [NCH-1:0]    analog_input_sel,
	output wire              sample_hold,
	output wire [RES_W-1:0]  dac_code,
	// standby and interrupt
	output reg               converter_standby,
	output wire              conv_end_irq
);

	// reset and fixed patterns at register width, so single bits can be picked out
	localparam [7:0] CTRL_RST    = `ADCC_CTRL_RST;
	localparam [7:0] START_FIXED = `ADCC_START_FIXED;

	// held write address and data
	reg              aw_held_ff;
	reg              w_held_ff;
	reg [ADDR_W-1:0] aw_addr_ff;
	reg [7:0]        w_byte_ff;
	reg              w_lane_ff;

	// software-visible state
	reg [7:0]        converter_mode_reg;
	reg [7:0]        clock_stop_reg_one;
	reg              start_busy_flag;
	reg              trigger_edge_select;
	reg              conversion_end_int_enable;
	reg              conversion_end_request;
	reg              trig_prev_ff;

	// write decode
	wire             wr_fire;
	wire [ADDR_W-3:0] wr_idx;
	wire             wr_mode;
	wire             wr_start;
	wire             wr_clkstop;
	wire             wr_ctrl;
	wire             wr_known;

	// start and stop control
	wire             trig_rise;
	wire             trig_fall;
	wire             trig_edge;
	wire             standby;
	wire             sw_start;
	wire             sw_stop;
	wire             start_req;
	wire             stop_req;
	wire             req_clr;
	wire             sar_done;
	wire [RES_W-1:0] result;
	wire [3:0]       ch;

	// read path
	wire             rd_fire;
	wire [ADDR_W-3:0] rd_idx;
	reg  [7:0]       rd_byte;
	reg              rd_ok;

	// protection bits carry no meaning for this block
	wire             prot_unused;
	assign prot_unused = ^{awprot, arprot, wstrb[3:1], wdata[31:8]};

	// a channel takes one item per ready/valid edge; each is held until paired
	assign awready = ~aw_held_ff;
	assign wready  = ~w_held_ff;
	assign wr_fire = aw_held_ff & w_held_ff & ~bvalid;
	assign wr_idx  = aw_addr_ff[ADDR_W-1:2];

	// register hits, only with byte lane 0 enabled
	assign wr_mode    = wr_fire & w_lane_ff & (wr_idx == `ADCC_IDX_MODE);
	assign wr_start   = wr_fire & w_lane_ff & (wr_idx == `ADCC_IDX_START);
	assign wr_clkstop = wr_fire & w_lane_ff & (wr_idx == `ADCC_IDX_CLKSTOP);
	assign wr_ctrl    = wr_fire & w_lane_ff & (wr_idx == `ADCC_IDX_CTRL);
	assign wr_known   = (wr_idx == `ADCC_IDX_MODE) | (wr_idx == `ADCC_IDX_START) |
	                    (wr_idx == `ADCC_IDX_CLKSTOP) | (wr_idx == `ADCC_IDX_CTRL) |
	                    (wr_idx == `ADCC_IDX_RES_HI) | (wr_idx == `ADCC_IDX_RES_LO);

	// capture address and data in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			aw_addr_ff <= {ADDR_W{1'b0}};
			w_byte_ff  <= 8'h00;
			w_lane_ff  <= 1'b0;
		end else begin
			if (awvalid && !aw_held_ff) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= awaddr;
			end else if (wr_fire) begin
				aw_held_ff <= 1'b0;
			end
			if (wvalid && !w_held_ff) begin
				w_held_ff <= 1'b1;
				w_byte_ff <= wdata[7:0];
				w_lane_ff <= wstrb[0];
			end else if (wr_fire) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	// write response; result registers are read-only, writes there are dropped quietly
	always @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `ADCC_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp  <= wr_known ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// trigger pin edges; the pin counts as synchronous to aclk
	assign trig_rise = external_trigger_pin & ~trig_prev_ff;
	assign trig_fall = ~external_trigger_pin & trig_prev_ff;
	assign trig_edge = converter_mode_reg[`ADCC_MODE_TRIG_EN] &
	                   (trigger_edge_select ? trig_rise : trig_fall);

	// module standby stops any conversion and refuses new ones
	assign standby   = ~clock_stop_reg_one[`ADCC_CLKSTOP_ADC];
	assign sw_start  = wr_start & w_byte_ff[`ADCC_START_FLAG];
	assign sw_stop   = wr_start & ~w_byte_ff[`ADCC_START_FLAG];
	assign start_req = (sw_start | trig_edge) & ~start_busy_flag & ~standby;
	assign stop_req  = start_busy_flag & (sw_stop | standby);

	always @(posedge aclk) begin
		if (!aresetn)
			trig_prev_ff <= 1'b0;
		else
			trig_prev_ff <= external_trigger_pin;
	end

	// mode, clock stop and start flag registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			converter_mode_reg <= `ADCC_MODE_RST;
			clock_stop_reg_one <= `ADCC_CLKSTOP_RST;
			start_busy_flag    <= 1'b0;
		end else begin
			// fixed bits are forced back so they always read as one
			if (wr_mode)
				converter_mode_reg <= (w_byte_ff & ~`ADCC_MODE_FIXED) | `ADCC_MODE_FIXED;
			if (wr_clkstop)
				clock_stop_reg_one <= (w_byte_ff & ~`ADCC_CLKSTOP_FIXED) | `ADCC_CLKSTOP_FIXED;
			if (start_req)
				start_busy_flag <= 1'b1;
			else if (sar_done || stop_req)
				start_busy_flag <= 1'b0;
		end
	end

	// end request: hardware set wins over a software clear in the same cycle
	assign req_clr = wr_ctrl & w_byte_ff[`ADCC_CTRL_REQ];
	always @(posedge aclk) begin
		if (!aresetn) begin
			trigger_edge_select       <= CTRL_RST[`ADCC_CTRL_EDGE];
			conversion_end_int_enable <= 1'b0;
			conversion_end_request    <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				trigger_edge_select       <= w_byte_ff[`ADCC_CTRL_EDGE];
				conversion_end_int_enable <= w_byte_ff[`ADCC_CTRL_IEN];
			end
			conversion_end_request <= sar_done | (conversion_end_request & ~req_clr);
		end
	end

	assign conv_end_irq = conversion_end_request & conversion_end_int_enable;

	// channel decode; no channel and prohibited codes select nothing
	assign ch = converter_mode_reg[3:0];
	always @(posedge aclk) begin
		if (!aresetn) begin
			analog_input_sel  <= {NCH{1'b0}};
			converter_standby <= 1'b0;
		end else begin
			converter_standby <= standby;
			case (ch[3:2])
				`ADCC_CH_GRP_LOW:  analog_input_sel <= {{(NCH-1){1'b0}}, 1'b1} << ch[1:0];
				`ADCC_CH_GRP_HIGH: analog_input_sel <= {{(NCH-1){1'b0}}, 1'b1} << {1'b1, ch[1:0]};
				default:           analog_input_sel <= {NCH{1'b0}};
			endcase
		end
	end

	// sequencer; the result store inside it is not reset
	adcc_sar #(
		.RES_W (RES_W),
		.CNT_W (6)
	) u_sar (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.start     (start_req),
		.stop      (stop_req),
		.fast      (converter_mode_reg[`ADCC_MODE_SPEED]),
		.cmp_high  (comparator_high),
		.sample_ff (sample_hold),
		.dac_ff    (dac_code),
		.done_ff   (sar_done),
		.result_ff (result),
		.busy      ()
	);

	// read decode; reserved low bits of the low byte read as zero
	assign rd_idx  = araddr[ADDR_W-1:2];
	assign arready = ~rvalid;
	assign rd_fire = arvalid & ~rvalid;

	always @* begin
		rd_byte = 8'h00;
		rd_ok   = 1'b1;
		case (rd_idx)
			`ADCC_IDX_RES_HI:  rd_byte = result[RES_W-1:2];
			`ADCC_IDX_RES_LO:  rd_byte = {result[1:0], 6'h00};
			`ADCC_IDX_MODE:    rd_byte = converter_mode_reg;
			`ADCC_IDX_START:   rd_byte = {start_busy_flag, START_FIXED[6:0]};
			`ADCC_IDX_CLKSTOP: rd_byte = clock_stop_reg_one;
			`ADCC_IDX_CTRL:    rd_byte = {5'h00, conversion_end_request,
			                              conversion_end_int_enable, trigger_edge_select};
			default:           rd_ok   = 1'b0;
		endcase
	end

	// read data from a register, held until rready
	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `ADCC_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid <= 1'b1;
			rdata  <= {24'h00_0000, rd_byte};
			rresp  <= rd_ok ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

//--- adcc_map.vh
// register map, field positions, reset values and timing counts of the converter control
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH

// register indices; byte address on the bus is index * 4
`define ADCC_IDX_RES_HI   16'hffc4
`define ADCC_IDX_RES_LO   16'hffc5
`define ADCC_IDX_MODE     16'hffc6
`define ADCC_IDX_START    16'hffc7
`define ADCC_IDX_CLKSTOP  16'hfffa
`define ADCC_IDX_CTRL     16'hffc8

// reset values
`define ADCC_MODE_RST     8'h30
`define ADCC_START_RST    8'h7f
`define ADCC_CLKSTOP_RST  8'hff
`define ADCC_CTRL_RST     8'h00

// bits that always read as 1 and ignore writes
`define ADCC_MODE_FIXED   8'h30
`define ADCC_START_FIXED  8'h7f
`define ADCC_CLKSTOP_FIXED 8'hc0

// field positions
`define ADCC_MODE_SPEED   7
`define ADCC_MODE_TRIG_EN 6
`define ADCC_START_FLAG   7
`define ADCC_CLKSTOP_ADC  4
`define ADCC_CTRL_EDGE    0
`define ADCC_CTRL_IEN     1
`define ADCC_CTRL_REQ     2

// channel field groups
`define ADCC_CH_GRP_LOW   2'b01
`define ADCC_CH_GRP_HIGH  2'b10

// conversion timing in system clock cycles
`define ADCC_RESULT_BITS  10
`define ADCC_SLOW_PERIOD  62
`define ADCC_FAST_PERIOD  31
`define ADCC_SLOW_STEP    4
`define ADCC_FAST_STEP    2

// shortest conversion time software may select; both speeds (62 and 31 cycles) stay below ADCC_MIN_CONV_CYC
`define ADCC_CLK_NS       10
`define ADCC_MIN_CONV_NS  6200
`define ADCC_MIN_CONV_CYC ((`ADCC_MIN_CONV_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)

// bus responses
`define ADCC_RESP_OKAY    2'b00
`define ADCC_RESP_SLVERR  2'b10

`endif

//--- adcc_sar.v
// successive-approximation sequencer: sample phase, then one result bit per step
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.vh"

module adcc_sar #(
	parameter RES_W = 10,
	parameter CNT_W = 6
) (
	// clock and reset
	input  wire             aclk,
	input  wire             aresetn,
	// control from the register side
	input  wire             start,
	input  wire             stop,
	input  wire             fast,
	// analog front end
	input  wire             cmp_high,
	output reg              sample_ff,
	output reg  [RES_W-1:0] dac_ff,
	// outcome
	output reg              done_ff,
	output reg  [RES_W-1:0] result_ff,
	output wire             busy
);

	localparam S_IDLE = 3'b001;
	localparam S_SAMP = 3'b010;
	localparam S_CONV = 3'b100;

	localparam [CNT_W-1:0] ONE       = 1;
	localparam [CNT_W-1:0] SLOW_STEP = `ADCC_SLOW_STEP;
	localparam [CNT_W-1:0] FAST_STEP = `ADCC_FAST_STEP;
	localparam [CNT_W-1:0] SLOW_SAMP = `ADCC_SLOW_PERIOD - `ADCC_RESULT_BITS * `ADCC_SLOW_STEP;
	localparam [CNT_W-1:0] FAST_SAMP = `ADCC_FAST_PERIOD - `ADCC_RESULT_BITS * `ADCC_FAST_STEP;
	localparam [RES_W-1:0] MSB_TRIAL = {1'b1, {(RES_W-1){1'b0}}};
	localparam [3:0]       TOP_BIT   = RES_W - 1;

	reg  [2:0]       state_ff;
	reg  [2:0]       nxt_state;
	reg  [CNT_W-1:0] cnt_ff;
	reg  [CNT_W-1:0] nxt_cnt;
	reg  [3:0]       bit_ff;
	reg  [3:0]       nxt_bit;
	reg  [RES_W-1:0] nxt_dac;
	reg              nxt_sample;
	reg              nxt_done;
	reg              fast_ff;
	reg              load;
	wire [CNT_W-1:0] step_len;
	wire [CNT_W-1:0] samp_len;

	// speed is frozen at start so a stray write cannot stretch a conversion
	assign step_len = fast_ff ? FAST_STEP : SLOW_STEP;
	assign samp_len = fast_ff ? FAST_SAMP : SLOW_SAMP;
	assign busy     = ~state_ff[0];

	// next-state logic: sample, then ten trial steps msb first
	always @* begin
		nxt_state  = state_ff;
		nxt_cnt    = cnt_ff;
		nxt_bit    = bit_ff;
		nxt_dac    = dac_ff;
		nxt_sample = sample_ff;
		nxt_done   = 1'b0;
		load       = 1'b0;
		case (state_ff)
			S_IDLE: begin
				if (start) begin
					nxt_state  = S_SAMP;
					nxt_cnt    = {CNT_W{1'b0}};
					nxt_sample = 1'b1;
					nxt_dac    = {RES_W{1'b0}};
				end
			end
			S_SAMP: begin
				if (cnt_ff == samp_len - ONE) begin
					nxt_state  = S_CONV;
					nxt_cnt    = {CNT_W{1'b0}};
					nxt_sample = 1'b0;
					nxt_bit    = TOP_BIT;
					nxt_dac    = MSB_TRIAL;
				end else begin
					nxt_cnt = cnt_ff + ONE;
				end
			end
			S_CONV: begin
				if (cnt_ff == step_len - ONE) begin
					nxt_cnt = {CNT_W{1'b0}};
					// keep the trial bit only if the input is at or above it
					if (!cmp_high)
						nxt_dac[bit_ff] = 1'b0;
					if (bit_ff == 4'd0) begin
						nxt_state = S_IDLE;
						nxt_done  = 1'b1;
						load      = 1'b1;
					end else begin
						nxt_bit = bit_ff - 4'd1;
						nxt_dac[bit_ff - 4'd1] = 1'b1;
					end
				end else begin
					nxt_cnt = cnt_ff + ONE;
				end
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
		// a stop abandons the conversion and leaves the old result
		if (stop) begin
			nxt_state  = S_IDLE;
			nxt_sample = 1'b0;
			nxt_done   = 1'b0;
			load       = 1'b0;
		end
	end

	// sequencer state
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_ff  <= S_IDLE;
			cnt_ff    <= {CNT_W{1'b0}};
			bit_ff    <= 4'd0;
			dac_ff    <= {RES_W{1'b0}};
			sample_ff <= 1'b0;
			done_ff   <= 1'b0;
			fast_ff   <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			cnt_ff    <= nxt_cnt;
			bit_ff    <= nxt_bit;
			dac_ff    <= nxt_dac;
			sample_ff <= nxt_sample;
			done_ff   <= nxt_done;
			if (start && state_ff[0])
				fast_ff <= fast;
		end
	end

	// result store has no reset: it survives a system reset
	always @(posedge aclk) begin
		if (load)
			result_ff <= nxt_dac;
	end

endmodule
`default_nettype wire

//--- adcc_ctrl_asserts.sv
// port checker for the converter control, bound to every instance
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_asserts #(
	parameter RES_W = 10,
	parameter NCH   = 8
) (
	// clock and reset
	input wire logic             aclk,
	input wire logic             aresetn,
	// read channel
	input wire logic             arvalid,
	input wire logic             arready,
	input wire logic [31:0]      rdata,
	input wire logic             rvalid,
	// analog side
	input wire logic [NCH-1:0]   analog_input_sel,
	input wire logic             sample_hold,
	input wire logic [RES_W-1:0] dac_code
);
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [5:0] hold_cnt_ff;
	logic [5:0] nxt_hold_cnt;
	// length of the running sample phase, zero between phases
	always_comb nxt_hold_cnt = sample_hold ? hold_cnt_ff + 6'h01 : 6'h00;
	always_ff @(posedge aclk) hold_cnt_ff <= aresetn ? nxt_hold_cnt : 6'h00;
	// the end of sampling opens the trial steps
	sequence s_sample_end;
		$fell(sample_hold);
	endsequence
	sequence s_msb_trial;
		##[0:1] dac_code[RES_W-1] && dac_code[RES_W-2:0] == 0;
	endsequence
	one_input_a: assert property ($onehot0(analog_input_sel))
		else $error("more than one input selected");
	input_steady_a: assert property ($past(sample_hold) && sample_hold |-> $stable(analog_input_sel))
		else $error("input changed while sampling");
	sample_len_a: assert property (s_sample_end |-> hold_cnt_ff == 6'h0b || hold_cnt_ff == 6'h16)
		else $error("sample phase length wrong");
	msb_first_a: assert property (s_sample_end |-> s_msb_trial)
		else $error("first trial is not the top bit");
	second_trial_a: assert property (s_sample_end |-> ##[1:5] dac_code[RES_W-2])
		else $error("second trial missing");
	no_resample_a: assert property (s_sample_end |-> !sample_hold [*8])
		else $error("sampling again inside the steps");
	read_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered");
	byte_lane_a: assert property (rvalid |-> rdata[31:8] == 24'h000000)
		else $error("upper read lanes not zero");
	cover property (s_sample_end);
endmodule
bind adcc_ctrl adcc_ctrl_asserts #(.RES_W(RES_W), .NCH(NCH)) u_adcc_ctrl_asserts (
	.aclk             (aclk),
	.aresetn          (aresetn),
	.arvalid          (arvalid),
	.arready          (arready),
	.rdata            (rdata),
	.rvalid           (rvalid),
	.analog_input_sel (analog_input_sel),
	.sample_hold      (sample_hold),
	.dac_code         (dac_code)
);
`default_nettype wire

//--- adcc_analog_model.sv
// analog front end model: eight input levels, sample-and-hold and comparator
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model (
	// clock
	input  wire logic        aclk,
	// converter side
	input  wire logic [7:0]  analog_input_sel,
	input  wire logic        sample_hold,
	input  wire logic [9:0]  dac_code,
	output var  logic        comparator_high,
	// levels set by the bench
	input  wire logic [79:0] levels
);
	logic [9:0] held_ff;
	// hold the selected level; no input selected samples ground
	always_ff @(posedge aclk) begin
		if (sample_hold) begin
			held_ff <= 10'h000;
			for (int k = 0; k < 8; k++)
				if (analog_input_sel[k]) held_ff <= levels[k*10 +: 10];
		end
	end
	// settles at once, so conversions shorter than the minimum time still give exact codes
	always_comb comparator_high = (held_ff >= dac_code);
endmodule
`default_nettype wire

//--- adcc_ctrl_tb.sv
// self-checking bench for the converter control
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.vh"
module adcc_ctrl_tb;
	localparam logic [15:0] i_hi = `ADCC_IDX_RES_HI;
	localparam logic [15:0] i_lo = `ADCC_IDX_RES_LO;
	localparam logic [15:0] i_md = `ADCC_IDX_MODE;
	localparam logic [15:0] i_st = `ADCC_IDX_START;
	localparam logic [15:0] i_ck = `ADCC_IDX_CLKSTOP;
	localparam logic [15:0] i_ct = `ADCC_IDX_CTRL;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [17:0] awaddr = 18'h00000;
	logic [17:0] araddr = 18'h00000;
	logic [31:0] wdata = 32'h00000000;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        external_trigger_pin = 1'b0;
	logic [79:0] levels = 80'h0;
	wire logic   awready, wready, bvalid, arready, rvalid, sample_hold, comparator_high;
	wire logic   converter_standby, conv_end_irq;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0]  analog_input_sel;
	wire logic [9:0]  dac_code;
	logic [7:0]  q;
	logic [1:0]  r;
	logic [9:0]  last_v;
	integer      failures = 0;
	integer      tests_run = 0;
	integer      cycles = 0;
	integer      k;
	integer      n;
	integer      seed;

	adcc_ctrl u_adcc_ctrl (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .external_trigger_pin(external_trigger_pin),
		.comparator_high(comparator_high), .analog_input_sel(analog_input_sel), .sample_hold(sample_hold),
		.dac_code(dac_code), .converter_standby(converter_standby), .conv_end_irq(conv_end_irq));
	adcc_analog_model u_adcc_analog_model (.aclk(aclk), .analog_input_sel(analog_input_sel),
		.sample_hold(sample_hold), .dac_code(dac_code), .comparator_high(comparator_high), .levels(levels));

	// free-running clock and hang guard
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			conclude;
		end
	end
	// mode byte for input ch
	function automatic logic [7:0] mode_of(input integer ch, input logic fast, input logic trg);
		mode_of = {fast, trg, 2'b11, ch[2], ~ch[2], ch[1:0]};
	endfunction
	// expected result byte, high or low half
	function automatic logic [7:0] res_of(input logic [9:0] val, input logic lo);
		res_of = lo ? {val[1:0], 6'h00} : val[9:2];
	endfunction
	task conclude;
		begin
			if (failures == 0 && tests_run > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// one bus transfer; each channel released only when its ready is seen
	task bus(input logic we, input logic [15:0] idx, input logic [7:0] d, output logic [7:0] qo,
		output logic [1:0] ro);
		begin
			if (we) begin
				awaddr <= {idx, 2'b00};
				wdata <= {24'h000000, d};
				awvalid <= 1'b1;
				wvalid <= 1'b1;
				bready <= 1'b1;
				do begin
					@(posedge aclk);
					if (awready) awvalid <= 1'b0;
					if (wready) wvalid <= 1'b0;
				end while (!bvalid);
				qo = 8'h00;
				ro = bresp;
			end else begin
				araddr <= {idx, 2'b00};
				arvalid <= 1'b1;
				rready <= 1'b1;
				do begin
					@(posedge aclk);
					if (arready) arvalid <= 1'b0;
				end while (!rvalid);
				qo = rdata[7:0];
				ro = rresp;
			end
		end
	endtask
	// read and compare data with an okay response
	task rchk(input logic [15:0] idx, input logic [7:0] exp);
		begin
			bus(1'b0, idx, 8'h00, q, r);
			chk({6'h00, r, q}, {8'h00, exp});
		end
	endtask
	// poll the start flag until the converter is idle
	task wait_idle;
		begin
			n = 0;
			q = 8'hff;
			while (q[7] === 1'b1 && n < 60) begin
				bus(1'b0, i_st, 8'h00, q, r);
				n = n + 1;
			end
			chk({8'h00, q}, 16'h007f);
		end
	endtask
	task conv(input integer ch, input logic fast, input logic [9:0] v);
		begin
			levels[ch*10 +: 10] <= v;
			last_v = v;
			bus(1'b1, i_md, mode_of(ch, fast, 1'b0), q, r);
			bus(1'b1, i_st, 8'h80, q, r);
			rchk(i_st, 8'hff);
			wait_idle;
			rchk(i_hi, res_of(v, 1'b0));
			rchk(i_lo, res_of(v, 1'b1));
		end
	endtask

	initial begin
		seed = $urandom(32'hfa23);
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(i_md, 8'h30);
		rchk(i_st, 8'h7f);
		rchk(i_ck, 8'hff);
		bus(1'b1, i_md, 8'h0f, q, r);
		rchk(i_md, 8'h3f);
		chk({8'h00, analog_input_sel}, 16'h0000);
		bus(1'b0, 16'h0100, 8'h00, q, r);
		chk({6'h00, r, q}, 16'h0200);
		// every input once, corner codes on inputs 0 and 7, then random ones
		for (k = 0; k < 8; k++)
			conv(k, 1'($urandom), k == 0 ? 10'h000 : k == 7 ? 10'h3ff : 10'($urandom));
		repeat (6) conv($urandom_range(7, 0), 1'($urandom), 10'($urandom));
		// read-only write ignored, result held while inputs move
		bus(1'b1, i_hi, 8'h55, q, r);
		chk({14'h0, r}, 16'h0000);
		levels <= ~levels;
		rchk(i_hi, res_of(last_v, 1'b0));
		// reset keeps the result but restores the mode
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(i_lo, res_of(last_v, 1'b1));
		rchk(i_md, 8'h30);
		// end request with and without its enable
		bus(1'b1, i_ct, 8'h02, q, r);
		conv(3, 1'b0, 10'h2aa);
		chk({15'h0, conv_end_irq}, 16'h0001);
		bus(1'b1, i_ct, 8'h06, q, r);
		chk({15'h0, conv_end_irq}, 16'h0000);
		bus(1'b1, i_ct, 8'h00, q, r);
		conv(5, 1'b0, 10'h155);
		chk({15'h0, conv_end_irq}, 16'h0000);
		rchk(i_ct, 8'h04);
		bus(1'b1, i_ct, 8'h04, q, r);
		// stop in the middle of the steps
		levels[50 +: 10] <= 10'h0f0;
		bus(1'b1, i_st, 8'h80, q, r);
		repeat (30) @(posedge aclk);
		bus(1'b1, i_st, 8'h00, q, r);
		rchk(i_st, 8'h7f);
		rchk(i_hi, res_of(10'h155, 1'b0));
		rchk(i_ct, 8'h00);
		// trigger pin: disabled, wrong edge, falling, then rising
		levels[20 +: 10] <= 10'h123;
		bus(1'b1, i_md, mode_of(2, 1'b0, 1'b0), q, r);
		external_trigger_pin <= 1'b1;
		repeat (4) @(posedge aclk);
		external_trigger_pin <= 1'b0;
		repeat (4) @(posedge aclk);
		rchk(i_st, 8'h7f);
		bus(1'b1, i_md, mode_of(2, 1'b0, 1'b1), q, r);
		external_trigger_pin <= 1'b1;
		repeat (4) @(posedge aclk);
		rchk(i_st, 8'h7f);
		external_trigger_pin <= 1'b0;
		repeat (4) @(posedge aclk);
		rchk(i_st, 8'hff);
		wait_idle;
		rchk(i_hi, res_of(10'h123, 1'b0));
		bus(1'b1, i_ct, 8'h01, q, r);
		external_trigger_pin <= 1'b1;
		repeat (4) @(posedge aclk);
		rchk(i_st, 8'hff);
		wait_idle;
		// standby refuses a start
		bus(1'b1, i_ck, 8'hef, q, r);
		rchk(i_ck, 8'hef);
		chk({15'h0, converter_standby}, 16'h0001);
		bus(1'b1, i_st, 8'h80, q, r);
		rchk(i_st, 8'h7f);
		conclude;
	end
endmodule
`default_nettype wire
